// ### src/hra_host_port.sv
`timescale 1ns/1ps
`include "hra_consts.svh"

// Contract
// - Direct access to control, vector, master control
// - Sixteen-register window on 16-byte boundary
// - Window address is base nibble plus low bits
// - Block port at code 11111, both alignments
// - Block access uses pointer, then increments
// - Limit counter decrements on block access
// - Zero limit aborts, sets error, raises level 0
// - Master cannot write base, pointer, limit
// - Six masked levels, global enable, priority
// - Falling edges on port lines set 1-3
// - Timer timeouts raise levels 4 and 5
// - Grant disables, saves state, fetches vector
// - Vector slots at byte pairs 0..11
// - Transfer flags raise level 0
// - Masked sources still set request bits
// - No request set until enable after reset
// - Port lines always usable as interrupts
// - One level reserved for master communication
// - Strobes both low reset; hold while data low
// - Latch select, address, direction on strobe rise
// - Drive wait low while access pending
module hra_host_port
  import hra_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic address_strobe_n,
  input wire logic data_strobe_n,
  input wire logic chip_sel_n,
  input wire logic rw,
  input wire logic [7:0] ad_in,
  output logic [7:0] ad_out,
  output logic ad_oe,
  output logic wait_oe,
  input wire logic shift_mode,
  input wire logic [7:0] p3_in,
  input wire logic t0_timeout,
  input wire logic t1_timeout,
  input wire logic fw_we,
  input wire logic [7:0] fw_addr,
  input wire logic [7:0] fw_wdata,
  output logic [7:0] fw_rdata,
  input wire logic fw_ei,
  input wire logic fw_di,
  input wire logic fw_eom,
  input wire logic fw_transfer_error_flag,
  input wire logic fw_iret,
  output logic irq_cycle,
  output logic [10:0] vec_addr,
  output logic [7:0] req_out,
  output logic dev_reset
);
  logic [7:0] rf [256];
  hra_state_t state;
  hra_state_t next_state;
  logic as_q;
  logic cs_q;
  logic rw_q;
  logic [7:0] addr_q;
  logic [7:0] p3_q;
  logic armed;
  logic next_armed;
  logic in_irq;
  logic next_in_irq;
  logic [3:0] wcnt;
  logic [3:0] next_wcnt;
  logic ds_q;
  logic wait_r;
  logic oe_r;
  logic [7:0] dout_r;
  logic rst_r;
  logic [7:0] next_dout;
  logic next_oe;
  logic next_wait;
  logic rst_any;
  logic limit_error_flag_set;
  logic [5:0] srcs;
  logic [5:0] reqs;
  logic gv;
  logic [2:0] glvl;
  logic ack;
  logic bin_valid;
  logic bin_ready;
  hra_req_t bin;
  logic bout_valid;
  logic bout_ready;
  hra_req_t bout;
  logic [7:0] fa;
  logic is_blk;
  logic blk_err;
  logic m_we;
  logic [7:0] m_wdata;

  // Map a five-bit master port code to a register file location.
  function automatic logic [7:0] hra_map(input logic [4:0] pa,
                                         input logic [3:0] base);
    if (pa == `HRA_PA_XFER_CTRL) begin
      return `HRA_LOC_XFER_CTRL;
    end else if (pa == `HRA_PA_MVEC) begin
      return `HRA_LOC_MVEC;
    end else if (pa == `HRA_PA_MIC) begin
      return `HRA_LOC_MIC;
    end else begin
      return {base, pa[3:0]};
    end
  endfunction : hra_map

  ////////////////////////////////////////////////////////////////////////
  // Strobe reset: both strobes low enters reset, held while data low.
  assign rst_any = srst || rst_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      rst_r <= 1'b0;
    end else if (!address_strobe_n && !data_strobe_n) begin
      rst_r <= 1'b1;
    end else if (data_strobe_n) begin
      rst_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Address phase capture on the rising strobe edge.
  always_ff @(posedge clk) begin
    if (rst_any) begin
      as_q <= 1'b1;
      ds_q <= 1'b1;
      cs_q <= 1'b1;
      rw_q <= 1'b1;
      addr_q <= 8'h00;
      p3_q <= 8'hFF;
    end else begin
      as_q <= address_strobe_n;
      ds_q <= data_strobe_n;
      p3_q <= p3_in;
      if (address_strobe_n && !as_q) begin
        cs_q <= chip_sel_n;
        rw_q <= rw;
        addr_q <= ad_in;
      end
    end
  end

  // Shifted mode drops bit 0 and decodes bits 1 to 5.
  always_comb begin
    is_blk = 1'b0;
    fa = 8'h00;
    if (shift_mode) begin
      is_blk = (addr_q[5:1] == `HRA_PA_BLOCK);
      fa = hra_map(addr_q[5:1], rf[`HRA_LOC_XFER_CTRL][7:4]);
    end else begin
      is_blk = (addr_q[4:0] == `HRA_PA_BLOCK);
      fa = hra_map(addr_q[4:0], rf[`HRA_LOC_XFER_CTRL][7:4]);
    end
    if (is_blk) begin
      fa = rf[`HRA_LOC_INDIR];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Data phase: hold wait low, then answer once the buffer takes the request.
  always_comb begin
    next_state = state;
    next_wcnt = wcnt;
    next_wait = wait_r;
    next_oe = oe_r;
    next_dout = dout_r;
    bin_valid = 1'b0;
    bin.wr = !rw_q && !blk_err;
    bin.addr = fa;
    bin.data = ad_in;
    unique case (state)
      HRA_IDLE: begin
        if (!data_strobe_n && ds_q && !cs_q) begin
          next_wait = 1'b1;
          next_wcnt = `HRA_WAIT_CYC;
          next_state = HRA_WAIT;
        end
      end
      HRA_WAIT: begin
        if (wcnt != 4'h0) begin
          next_wcnt = wcnt - 4'h1;
        end else if (bin_ready) begin
          bin_valid = 1'b1;
          next_dout = rf[fa];
          next_oe = rw_q;
          next_wait = 1'b0;
          next_state = HRA_DONE;
        end
      end
      HRA_DONE: begin
        if (data_strobe_n) begin
          next_oe = 1'b0;
          next_state = HRA_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst_any) begin
      state <= HRA_IDLE;
      wcnt <= 4'h0;
      wait_r <= 1'b0;
      oe_r <= 1'b0;
      dout_r <= 8'h00;
    end else begin
      state <= next_state;
      wcnt <= next_wcnt;
      wait_r <= next_wait;
      oe_r <= next_oe;
      dout_r <= next_dout;
    end
  end

  // Buffer absorbs a request while firmware owns the file write port.
  assign bout_ready = !fw_we;

  hra_buf2 u_buf (
    .clk(clk),
    .srst(rst_any),
    .in_valid(bin_valid),
    .in_ready(bin_ready),
    .in_data(bin),
    .out_valid(bout_valid),
    .out_ready(bout_ready),
    .out_data(bout)
  );

  // A block request against an exhausted limit is refused. The verdict
  // is taken as the request enters the buffer, before pointer and limit
  // move, so the last legal byte is never mistaken for an overrun.
  assign blk_err = is_blk && rf[`HRA_LOC_LIMIT] == 8'h00;

  ////////////////////////////////////////////////////////////////////////
  // Interrupt sources, levels 0 to 5.
  assign limit_error_flag_set = bin_valid && is_blk &&
                    rf[`HRA_LOC_LIMIT] == 8'h00;
  always_comb begin
    srcs[0] = fw_eom || fw_transfer_error_flag || limit_error_flag_set;
    srcs[1] = p3_q[3] && !p3_in[3];
    srcs[2] = p3_q[1] && !p3_in[1];
    srcs[3] = p3_q[0] && !p3_in[0];
    srcs[4] = t0_timeout;
    srcs[5] = t1_timeout;
  end

  assign ack = gv && !in_irq;

  hra_irq u_irq (
    .clk(clk),
    .srst(rst_any),
    .src_pulse(srcs),
    .req_arm(armed),
    .mask(rf[`HRA_LOC_IMASK] & {armed, 7'h7F}),
    .prio(rf[`HRA_LOC_IPRIO]),
    .req_clear((fw_we && fw_addr == `HRA_LOC_IREQ) ? ~fw_wdata[5:0] :
               6'h00),
    .ack(ack),
    .req(reqs),
    .grant_valid(gv),
    .grant_lvl(glvl)
  );

  // Enable arms request setting after reset; grant blocks nesting.
  always_comb begin
    next_armed = armed || fw_ei;
    next_in_irq = in_irq;
    if (ack || fw_di) begin
      next_in_irq = 1'b1;
    end else if (fw_iret || fw_ei) begin
      next_in_irq = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst_any) begin
      armed <= 1'b0;
      in_irq <= 1'b0;
      irq_cycle <= 1'b0;
      vec_addr <= 11'h000;
      req_out <= 8'h00;
    end else begin
      armed <= next_armed;
      in_irq <= next_in_irq;
      irq_cycle <= ack;
      if (ack) begin
        vec_addr <= {7'h00, glvl, 1'b0};
      end
      req_out <= {2'b00, reqs};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register file: firmware first, then master traffic and side effects.
  assign m_we = bout_valid && bout_ready && bout.wr;
  assign m_wdata = bout.data;

  always_ff @(posedge clk) begin
    if (fw_we) begin
      rf[fw_addr] <= fw_wdata;
    end else if (m_we) begin
      if (bout.addr == `HRA_LOC_XFER_CTRL) begin
        rf[bout.addr] <= {rf[bout.addr][7:4], m_wdata[3:0]};
      end else if (bout.addr != `HRA_LOC_LIMIT &&
                   bout.addr != `HRA_LOC_INDIR) begin
        rf[bout.addr] <= m_wdata;
      end
    end
    if (bin_valid && is_blk && rf[`HRA_LOC_LIMIT] != 8'h00) begin
      rf[`HRA_LOC_INDIR] <= rf[`HRA_LOC_INDIR] + 8'h01;
      rf[`HRA_LOC_LIMIT] <= rf[`HRA_LOC_LIMIT] - 8'h01;
    end
    if (limit_error_flag_set) begin
      rf[`HRA_LOC_XFER_CTRL][`HRA_BIT_LIMIT_ERROR_FLAG] <= 1'b1;
    end
    if (fw_eom) begin
      rf[`HRA_LOC_XFER_CTRL][`HRA_BIT_EOM] <= 1'b1;
    end
    if (fw_transfer_error_flag) begin
      rf[`HRA_LOC_XFER_CTRL][`HRA_BIT_TRANSFER_ERROR_FLAG] <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs and firmware read port.
  // Registered so every port leaves from a flop; firmware sees its read
  // one clock after it presents the address.
  always_ff @(posedge clk) begin
    if (fw_addr == `HRA_LOC_IREQ) begin
      fw_rdata <= {2'b00, reqs};
    end else begin
      fw_rdata <= rf[fw_addr];
    end
  end

  assign ad_out = dout_r;
  assign ad_oe = oe_r;
  assign wait_oe = wait_r;
  assign dev_reset = rst_r;
endmodule : hra_host_port

// ### src/hra_consts.svh
`ifndef HRA_CONSTS_SVH
`define HRA_CONSTS_SVH
// Register file locations.
`define HRA_LOC_XFER_CTRL 8'h00
`define HRA_LOC_LIMIT 8'h04
`define HRA_LOC_INDIR 8'h05
`define HRA_LOC_MVEC 8'hF0
`define HRA_LOC_IPRIO 8'hF9
`define HRA_LOC_IREQ 8'hFA
`define HRA_LOC_IMASK 8'hFB
`define HRA_LOC_MIC 8'hFE
// Master-side five-bit port codes.
`define HRA_PA_XFER_CTRL 5'h18
`define HRA_PA_MVEC 5'h10
`define HRA_PA_MIC 5'h1E
`define HRA_PA_BLOCK 5'h1F
// Transfer control and interrupt mask bit positions.
`define HRA_BIT_EOM 0
`define HRA_BIT_TRANSFER_ERROR_FLAG 1
`define HRA_BIT_LIMIT_ERROR_FLAG 2
`define HRA_BIT_GIE 7
// Master wait stretch in clocks.
`define HRA_WAIT_CYC 4'h2
`endif

// ### src/hra_pkg.sv
package hra_pkg;
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] data;
  } hra_req_t;
  typedef enum logic [1:0] {
    HRA_IDLE,
    HRA_WAIT,
    HRA_DONE
  } hra_state_t;
endpackage : hra_pkg

// ### src/hra_buf2.sv
`timescale 1ns/1ps
// Two-entry skid buffer carrying master requests to the file port.
module hra_buf2
  import hra_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic in_valid,
  output logic in_ready,
  input wire hra_req_t in_data,
  output logic out_valid,
  input wire logic out_ready,
  output hra_req_t out_data
);
  hra_req_t mem [2];
  logic [1:0] cnt;
  logic wp;
  logic rp;
  logic push;
  logic pop;
  logic [1:0] next_cnt;

  ////////////////////////////////////////////////////////////////////////
  // Occupancy follows pushes and pops; full stalls the source.
  always_comb begin
    push = in_valid && (cnt != 2'h2);
    pop = out_valid && out_ready;
    next_cnt = cnt + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt <= 2'h0;
      wp <= 1'b0;
      rp <= 1'b0;
    end else begin
      cnt <= next_cnt;
      if (push) begin
        wp <= ~wp;
      end
      if (pop) begin
        rp <= ~rp;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp] <= in_data;
    end
  end

  assign in_ready = (cnt != 2'h2);
  assign out_valid = (cnt != 2'h0);
  assign out_data = mem[rp];
endmodule : hra_buf2

// ### src/hra_irq.sv
`timescale 1ns/1ps
// Six-level request latch, mask gate and priority pick.
module hra_irq
  import hra_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [5:0] src_pulse,
  input wire logic req_arm,
  input wire logic [7:0] mask,
  input wire logic [7:0] prio,
  input wire logic [5:0] req_clear,
  input wire logic ack,
  output logic [5:0] req,
  output logic grant_valid,
  output logic [2:0] grant_lvl
);
  logic [5:0] next_req;
  logic [5:0] pend;

  ////////////////////////////////////////////////////////////////////////
  // Requests latch even when masked so firmware may poll them.
  always_comb begin
    next_req = req & ~req_clear;
    if (ack && grant_valid) begin
      next_req[grant_lvl] = 1'b0;
    end
    if (req_arm) begin
      next_req = next_req | src_pulse;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      req <= 6'h00;
    end else begin
      req <= next_req;
    end
  end

  // Priority: low bit of prio picks descending order, else ascending.
  // Requests with global enable off stay pending and ungranted.
  always_comb begin
    pend = req & mask[5:0] & {6{mask[`HRA_BIT_GIE]}};
    grant_valid = 1'b0;
    grant_lvl = 3'h0;
    for (int i = 0; i < 6; i++) begin
      if (prio[0]) begin
        if (pend[5 - i] && !grant_valid) begin
          grant_valid = 1'b1;
          grant_lvl = 3'(5 - i);
        end
      end else if (pend[i] && !grant_valid) begin
        grant_valid = 1'b1;
        grant_lvl = 3'(i);
      end
    end
  end
endmodule : hra_irq

// ### verif/hra_chk.sv
`timescale 1ns/1ps
// Watches strobe timing and request behaviour at the port pins.
module hra_chk (
  input wire logic clk,
  input wire logic srst,
  input wire logic address_strobe_n,
  input wire logic data_strobe_n,
  input wire logic rw,
  input wire logic wait_oe,
  input wire logic ad_oe,
  input wire logic dev_reset,
  input wire logic fw_ei,
  input wire logic [7:0] req_out,
  input wire logic irq_cycle,
  input wire logic [10:0] vec_addr
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  logic armed;
  logic next_armed;
  // Either reset disarms request latching until the next enable.
  always_comb next_armed = (srst | dev_reset) ? 1'b0 : (armed | fw_ei);
  always_ff @(posedge clk) armed <= next_armed;
  //////////////////////////////////////////////////////////////////////
  chk_wait_rise: assert property (
    $fell(data_strobe_n) && address_strobe_n |=> wait_oe)
    else $error("wait not raised");
  chk_wait_bound: assert property (
    $rose(wait_oe) |-> ##[1:8] !wait_oe)
    else $error("wait held too long");
  chk_read_drive: assert property (
    $fell(wait_oe) |-> ad_oe == rw)
    else $error("data drive wrong");
  chk_oe_release: assert property (
    $rose(data_strobe_n) |-> ##[1:2] !ad_oe)
    else $error("data drive held");
  chk_reset_hold: assert property (
    !data_strobe_n && (dev_reset || !address_strobe_n) |=> dev_reset)
    else $error("strobe reset lost");
  chk_no_early: assert property (
    !armed && !fw_ei && req_out == 8'h00 |=> req_out == 8'h00)
    else $error("request before enable");
  chk_grant_vec: assert property (
    irq_cycle |-> !vec_addr[0] && vec_addr < 11'h00C)
    else $error("vector slot wrong");
  chk_grant_once: assert property (
    irq_cycle |=> !irq_cycle)
    else $error("grant repeated");
  cover property ($fell(wait_oe) && rw);
  cover property (irq_cycle);
  cover property ($rose(dev_reset));
endmodule : hra_chk

bind hra_host_port hra_chk u_chk (.clk, .srst, .address_strobe_n,
  .data_strobe_n, .rw, .wait_oe, .ad_oe, .dev_reset, .fw_ei, .req_out,
  .irq_cycle, .vec_addr);

// ### verif/hra_mst.sv
`timescale 1ns/1ps
// Master CPU model on the multiplexed strobe bus.
module hra_mst (
  input wire logic clk,
  input wire logic sh,
  input wire logic wait_oe,
  input wire logic [7:0] ad_out,
  output logic as_n,
  output logic ds_n,
  output logic cs_n,
  output logic rw,
  output logic [7:0] ad
);
  // Idle bus with both strobes high.
  initial begin
    as_n = 1'b1;
    ds_n = 1'b1;
    cs_n = 1'b1;
    rw = 1'b1;
    ad = 8'h00;
  end
  //////////////////////////////////////////////////////////////////////
  // One byte; lines not driven carry the inverse of their last value.
  task automatic acc(input logic w, input logic [4:0] c,
    input logic [7:0] d, output logic [7:0] q);
    int n;
    @(negedge clk);
    cs_n = 1'b0;
    rw = ~w;
    ad = sh ? {2'b00, c, 1'b0} : {3'b000, c};
    as_n = 1'b0;
    @(negedge clk);
    as_n = 1'b1;
    @(negedge clk);
    ad = w ? d : ~ad;
    ds_n = 1'b0;
    n = 0;
    while (wait_oe !== 1'b1 && n < 9) begin
      @(negedge clk);
      n++;
    end
    while (wait_oe !== 1'b0 && n < 30) begin
      @(negedge clk);
      n++;
    end
    q = ad_out;
    @(negedge clk);
    ds_n = 1'b1;
    cs_n = 1'b1;
    ad = ~ad;
    repeat (2) @(negedge clk);
  endtask : acc
  // Both strobes low resets; the hold lasts while the data strobe is low.
  task automatic srs(input int k);
    @(negedge clk);
    as_n = 1'b0;
    ds_n = 1'b0;
    repeat (k) @(negedge clk);
    ds_n = 1'b1;
    as_n = 1'b1;
    repeat (2) @(negedge clk);
  endtask : srs
endmodule : hra_mst

// ### verif/hra_host_port_tb.sv
`timescale 1ns/1ps
`include "hra_consts.svh"
// Self-checking bench for the host register port.
module hra_host_port_tb;
  import hra_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic shift_mode = 1'b0;
  logic fw_we = 1'b0;
  logic [6:0] fp = 7'h00;
  logic [7:0] p3_in = 8'hFF;
  logic [7:0] fw_addr = 8'h00;
  logic [7:0] fw_wdata = 8'h00;
  logic [31:0] lf = 32'hDF8C210F;
  logic address_strobe_n, data_strobe_n, chip_sel_n, rw, ad_oe, wait_oe;
  logic irq_cycle, dev_reset;
  logic [7:0] ad_in, ad_out, fw_rdata, req_out, q;
  logic [10:0] vec_addr;
  int failures = 0;
  int check_count = 0;
  int cyc = 0;
  int i;
  int m [256];
  int ln [3] = '{3, 1, 0};
  always #2.5 clk = ~clk;
  //////////////////////////////////////////////////////////////////////
  hra_host_port DUT (.clk, .srst, .address_strobe_n, .data_strobe_n,
    .chip_sel_n, .rw, .ad_in, .ad_out, .ad_oe, .wait_oe, .shift_mode,
    .p3_in, .t0_timeout(fp[5]), .t1_timeout(fp[6]), .fw_we, .fw_addr,
    .fw_wdata, .fw_rdata, .fw_ei(fp[0]), .fw_di(fp[1]), .fw_eom(fp[2]),
    .fw_transfer_error_flag(fp[3]), .fw_iret(fp[4]), .irq_cycle, .vec_addr, .req_out,
    .dev_reset);
  hra_mst M (.clk, .sh(shift_mode), .wait_oe, .ad_out,
    .as_n(address_strobe_n), .ds_n(data_strobe_n), .cs_n(chip_sel_n),
    .rw, .ad(ad_in));
  // A hung run counts as a mismatch.
  always @(posedge clk) begin
    cyc++;
    if (cyc > 4000) begin
      failures++;
      results();
    end
  end
  task automatic results();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : results
  task automatic chk(input logic [10:0] g, input logic [10:0] e);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // Firmware side write, read and one-cycle pulses.
  task automatic fw(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    fw_we = 1'b1;
    fw_addr = a;
    fw_wdata = d;
    m[a] = d;
    @(negedge clk);
    fw_we = 1'b0;
  endtask : fw
  task automatic fr(input logic [7:0] a);
    @(negedge clk);
    fw_addr = a;
    @(negedge clk);
    q = fw_rdata;
  endtask : fr
  task automatic pl(input logic [6:0] v);
    @(negedge clk);
    fp = v;
    @(negedge clk);
    fp = 7'h00;
  endtask : pl
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nx
  // Main sequence; the model array m mirrors the register file.
  initial begin
    repeat (8) @(posedge clk);
    @(negedge clk);
    srst = 1'b0;
    p3_in = 8'hF4;
    pl(7'h60);
    chk(req_out, 0);
    fw(8'hF7, 8'hFF);
    fw(`HRA_LOC_IMASK, 8'h00);
    fw(`HRA_LOC_IPRIO, 8'h00);
    pl(7'h01);
    for (i = 0; i < 3; i++) begin
      p3_in = 8'hFF;
      pl(7'h00);
      p3_in[ln[i]] = 1'b0;
      pl(7'h00);
      chk(req_out[i + 1], 1);
    end
    pl(7'h20);
    pl(7'h40);
    fr(`HRA_LOC_IREQ);
    chk(q, 8'h3E);
    for (i = 4; i < 6; i++) begin
      fw(`HRA_LOC_IREQ, 8'h00);
      pl(7'h01);
      pl(7'(1 << (i + 1)));
      fw(`HRA_LOC_IMASK, 8'(8'h80 | (1 << i)));
      while (irq_cycle !== 1'b1 && cyc < 3000) @(negedge clk);
      chk(vec_addr, 11'(2 * i));
      fw(`HRA_LOC_IMASK, 8'h00);
    end
    fw(`HRA_LOC_IREQ, 8'h00);
    pl(7'h01);
    fw(`HRA_LOC_LIMIT, 8'h02);
    fw(`HRA_LOC_INDIR, 8'h33);
    fw(8'h35, 8'h5A);
    fw(`HRA_LOC_XFER_CTRL, 8'h00);
    for (i = 4; i < 6; i++) begin
      M.acc(1'b1, 5'(i), 8'hAA, q);
      fr(8'(i));
      chk(q, m[i]);
    end
    fw(`HRA_LOC_XFER_CTRL, 8'h30);
    for (i = 0; i < 2; i++) begin
      shift_mode = i[0];
      lf = nx(lf);
      m[8'h37] = lf[7:0];
      M.acc(1'b1, 5'h07, lf[7:0], q);
      fr(8'h37);
      chk(q, m[8'h37]);
      M.acc(1'b0, 5'h07, 8'h00, q);
      chk(q, m[8'h37]);
    end
    for (i = 0; i < 3; i++) begin
      lf = nx(lf);
      M.acc(1'b1, `HRA_PA_BLOCK, lf[7:0], q);
      if (m[4] > 0) begin
        m[m[5]] = lf[7:0];
        m[5]++;
        m[4]--;
      end else begin
        m[0] = m[0] | 4;
      end
      fr(8'h33 + 8'(i));
      chk(q, m[8'h33 + i]);
      fr(`HRA_LOC_INDIR);
      chk(q, m[5]);
      fr(`HRA_LOC_LIMIT);
      chk(q, m[4]);
    end
    fr(`HRA_LOC_XFER_CTRL);
    chk({q, req_out[0]}, {8'(m[0]), 1'b1});
    M.acc(1'b1, `HRA_PA_XFER_CTRL, 8'hF0, q);
    fr(`HRA_LOC_XFER_CTRL);
    chk(q[7:4], 4'h3);
    lf = nx(lf);
    M.acc(1'b1, `HRA_PA_MVEC, lf[7:0], q);
    fr(`HRA_LOC_MVEC);
    chk(q, lf[7:0]);
    pl(7'h0C);
    fr(`HRA_LOC_XFER_CTRL);
    chk(q[1:0], 2'h3);
    fork
      M.srs(4);
      begin
        repeat (3) @(negedge clk);
        chk(dev_reset, 1);
      end
    join
    chk(dev_reset, 0);
    pl(7'h20);
    chk(req_out, 0);
    results();
  end
endmodule : hra_host_port_tb
